// ### dv/tb.sv
// Purpose: Self-checking bench for the OTP/EEPROM program control block
// Assumes: Ack one cycle after a request; arrays start unknown
// Notes:   First reset runs in bootstrap so the upper EEPROM is writable
`timescale 1ns/10ps
module tb;
    import nvpc_pkg::*;
    // ==========================================================
    // Addresses on the byte-addressed bus
    localparam logic [15:0] A_CTL = 16'h001C;
    localparam logic [15:0] A_OPT = 16'h0400;
    localparam logic [15:0] A_EE2 = 16'h0480;
    localparam logic [15:0] A_OTP = 16'hF400;
    localparam logic [15:0] A_FIX = 16'hF7F8;
    localparam logic [15:0] A_OFF = 16'h0040;
    logic        CLK, RST_N, CYC_I, STB_I, WE_I, ACK_O;
    logic        STOP_MODE, WAIT_MODE, BOOT_MODE, POR_FLAG, UV_ERASE;
    logic        RESET_HOLD_N, WDOG_DEFAULT_ON, WDOG_WAIT_RUN;
    logic        SECURE_LOCK, VECTOR_BLOCK, PUMP_ON, OTP_PGM_ON;
    logic [15:0] ADR_I;
    logic [31:0] DAT_I, DAT_O;
    logic [7:0]  DDRB, DDRC, PB_PULLDOWN, PC_PULLDOWN;
    int          failures, n_tests;

    nvpc_ctrl uut (
        .CLK(CLK), .RST_N(RST_N), .CYC_I(CYC_I), .STB_I(STB_I),
        .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(4'hF), .DAT_I(DAT_I),
        .DAT_O(DAT_O), .ACK_O(ACK_O), .STOP_MODE(STOP_MODE),
        .WAIT_MODE(WAIT_MODE), .BOOT_MODE(BOOT_MODE), .POR_FLAG(POR_FLAG),
        .UV_ERASE(UV_ERASE), .DDRB(DDRB), .DDRC(DDRC),
        .RESET_HOLD_N(RESET_HOLD_N), .WDOG_DEFAULT_ON(WDOG_DEFAULT_ON),
        .WDOG_WAIT_RUN(WDOG_WAIT_RUN), .PB_PULLDOWN(PB_PULLDOWN),
        .PC_PULLDOWN(PC_PULLDOWN), .SECURE_LOCK(SECURE_LOCK),
        .VECTOR_BLOCK(VECTOR_BLOCK), .PUMP_ON(PUMP_ON),
        .OTP_PGM_ON(OTP_PGM_ON)
    );

    // ==========================================================
    // Clock and watchdog
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    // Generous: the run needs well under 20 us
    initial begin
        #100000;
        failures++;
        end_sim();
    end

    // ==========================================================
    // Shared tasks
    task automatic end_sim();
        $display("Checks run: %0d, mismatches: %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Classic cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [15:0] adr,
                      input logic [7:0] dat, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge CLK);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I  <= we;
        ADR_I <= adr;
        DAT_I <= {24'h000000, dat};
        do begin
            @(posedge CLK);
            n++;
        end while (ACK_O !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        rd = DAT_O[7:0];
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] adr, input logic [7:0] dat);
        logic [7:0] d;
        wb(1'b1, adr, dat, d);
    endtask

    task automatic rd_chk(input logic [15:0] adr, input logic [7:0] exp);
        logic [7:0] d;
        wb(1'b0, adr, 8'h00, d);
        chk(d, exp);
    endtask

    // Latch, capture address, pump on, end by clearing latch
    task automatic ee_op(input logic [7:0] m, input logic [15:0] adr,
                         input logic [7:0] dat);
        wr(A_CTL, m);
        wr(adr, dat);
        wr(A_CTL, m | 8'h01);
        wr(A_CTL, 8'h00);
    endtask

    task automatic otp_pass(input logic [7:0] dat);
        wr(A_CTL, 8'h20);
        wr(A_FIX, dat);
        wr(A_CTL, 8'h30);
        wr(A_CTL, 8'h00);
    endtask

    task automatic rst(input logic boot, input logic por);
        @(posedge CLK);
        RST_N     <= 1'b0;
        BOOT_MODE <= boot;
        POR_FLAG  <= por;
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
    endtask

    task automatic pulse_stop();
        @(posedge CLK);
        STOP_MODE <= 1'b1;
        @(posedge CLK);
        STOP_MODE <= 1'b0;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {RST_N, CYC_I, STB_I, WE_I, STOP_MODE, WAIT_MODE} = 6'h00;
        {BOOT_MODE, POR_FLAG, UV_ERASE, ADR_I, DAT_I} = '0;
        DDRB = 8'h0F;
        DDRC = 8'hA5;
        failures = 0;
        n_tests = 0;
        rst(1'b1, 1'b0);
        rd_chk(A_CTL, CTL_RESET);
        @(posedge CLK);
        UV_ERASE <= 1'b1;
        @(posedge CLK);
        UV_ERASE <= 1'b0;
        rd_chk(A_OTP, OTP_ERASED);
        // OTP: latch, refused enable, capture, commit
        wr(A_CTL, 8'h20);
        #1 chk({7'h00, VECTOR_BLOCK}, 8'h01);
        rd_chk(A_OTP, OTP_LATCH_READ);
        wr(A_CTL, 8'h30);
        rd_chk(A_CTL, 8'h20);
        wr(A_FIX, 8'h11);
        wr(A_FIX + 16'h0004, 8'h05);
        wr(A_CTL, 8'h30);
        #1 chk({7'h00, OTP_PGM_ON}, 8'h01);
        wr(A_CTL, 8'h20);
        rd_chk(A_CTL, 8'h30);
        rd_chk(A_FIX, OTP_LATCH_READ);
        wr(A_CTL, 8'h00);
        rd_chk(A_CTL, 8'h00);
        rd_chk(A_FIX, 8'h11);
        rd_chk(A_FIX + 16'h0004, 8'h05);
        otp_pass(8'h0A);
        rd_chk(A_FIX, 8'h1B);
        rd_chk(A_FIX + 16'h0004, 8'h05);
        wr(A_FIX, 8'hE4);
        rd_chk(A_FIX, 8'h1B);
        // Stop drops both latches
        wr(A_CTL, 8'h22);
        pulse_stop();
        rd_chk(A_CTL, 8'h00);
        #1 chk({7'h00, VECTOR_BLOCK}, 8'h00);
        // EEPROM: pump refused before capture, mode frozen
        wr(A_CTL, 8'h02);
        wr(A_CTL, 8'h03);
        rd_chk(A_CTL, 8'h02);
        wr(A_CTL, 8'h06);
        wr(A_OPT, 8'h00);
        wr(A_CTL, 8'h07);
        #1 chk({7'h00, PUMP_ON}, 8'h01);
        wr(A_CTL, 8'h03);
        rd_chk(A_CTL, 8'h07);
        wr(A_CTL, 8'h00);
        rd_chk(A_CTL, 8'h00);
        #1 chk({7'h00, PUMP_ON}, 8'h00);
        rd_chk(A_OPT, EE_ERASED);
        ee_op(8'h02, A_OPT, 8'h01);
        rd_chk(A_OPT, 8'h01);
        ee_op(8'h06, A_EE2, 8'h00);
        ee_op(8'h02, A_EE2, 8'h5A);
        rd_chk(A_EE2, 8'h5A);
        wr(A_EE2, 8'h00);
        rd_chk(A_EE2, 8'h5A);
        // Power-on reset with short hold and options now valid
        rst(1'b0, 1'b1);
        repeat (16) @(posedge CLK);
        #1 chk({7'h00, RESET_HOLD_N}, 8'h00);
        @(posedge CLK);
        #1 chk({7'h00, RESET_HOLD_N}, 8'h01);
        chk({7'h00, WDOG_DEFAULT_ON}, 8'h01);
        chk({7'h00, SECURE_LOCK}, 8'h00);
        chk(PB_PULLDOWN, 8'hF0);
        chk(PC_PULLDOWN, 8'h5A);
        // All port B pins to outputs: no pull-down may stay on
        @(posedge CLK);
        WAIT_MODE <= 1'b1;
        DDRB      <= 8'hFF;
        repeat (3) @(posedge CLK);
        #1 chk({7'h00, WDOG_WAIT_RUN}, 8'h00);
        chk(PB_PULLDOWN, 8'h00);
        @(posedge CLK);
        WAIT_MODE <= 1'b0;
        repeat (3) @(posedge CLK);
        #1 chk({7'h00, WDOG_WAIT_RUN}, 8'h01);
        // Upper part now protected, lower part still works
        ee_op(8'h06, A_EE2, 8'h00);
        rd_chk(A_EE2, 8'h5A);
        ee_op(8'h06, A_OPT, 8'h00);
        rd_chk(A_OPT, EE_ERASED);
        // Erased protect option opens the upper part at once
        ee_op(8'h02, A_EE2, 8'h48);
        rd_chk(A_EE2, 8'h48);
        ee_op(8'h02, A_OPT, 8'h00);
        #1 chk({7'h00, SECURE_LOCK}, 8'h00);
        // External reset into bootstrap: watchdog default stays off
        rst(1'b1, 1'b0);
        @(posedge CLK);
        #1 chk({7'h00, RESET_HOLD_N}, 8'h01);
        chk({7'h00, SECURE_LOCK}, 8'h01);
        chk({7'h00, WDOG_DEFAULT_ON}, 8'h00);
        rd_chk(A_OFF, 8'h00);
        rd_chk(A_EE2, 8'h48);
        end_sim();
    end
endmodule // tb

// ### logic/nvpc_ctrl.sv
// What this block does
// - OTP reads while latched return dummy data
// - Vector and boot fetches blocked while latched
// - Stop and reset clear OTP latch
// - Erased OTP byte reads as zero
// - OTP programming only sets bits
// - Latched OTP writes capture address and data
// - Program enable needs latch plus data
// - EEPROM mode bit selects erase or program
// - Mode bit frozen after address capture
// - EEPROM latch low forces mode, pump off
// - Stop and reset clear EEPROM latch
// - Pump settable only after data captured
// - Power-on reset hold 16 or 4064 cycles
// - Watchdog on after reset when optioned, except in bootstrap mode
// - Watchdog runs in wait when optioned
// - Port pull-downs only on inputs
// - Upper EEPROM part write protected
// - Protect clear needs latch; unprotect sticky
// - No EEPROM protection in bootstrap mode
// - Security lock taken at reset only
//
// Purpose: Control register, OTP and EEPROM arrays, option bit effects
// Assumes: Classic Wishbone slave, ack one cycle after request
// Notes:   Programming commits when the latch enable is cleared
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/10ps
module nvpc_ctrl (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [15:0] ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    input  wire logic        STOP_MODE,
    input  wire logic        WAIT_MODE,
    input  wire logic        BOOT_MODE,
    input  wire logic        POR_FLAG,
    input  wire logic        UV_ERASE,
    input  wire logic [7:0]  DDRB,
    input  wire logic [7:0]  DDRC,
    output logic             RESET_HOLD_N,
    output logic             WDOG_DEFAULT_ON,
    output logic             WDOG_WAIT_RUN,
    output logic [7:0]       PB_PULLDOWN,
    output logic [7:0]       PC_PULLDOWN,
    output logic             SECURE_LOCK,
    output logic             VECTOR_BLOCK,
    output logic             PUMP_ON,
    output logic             OTP_PGM_ON
);
    import nvpc_pkg::*;

    // ==========================================================
    // Storage and state
    logic [7:0]        otp_mem   [0:255];
    logic [7:0]        ee_mem    [0:255];
    nvpc_ctl_t         ctl_ff,   nxt_ctl;
    nvpc_ee_st_t       ee_st_ff, nxt_ee_st;
    logic [7:0]        otp_dat_ff [0:OTP_BYTES-1];
    logic [7:0]        nxt_otp_dat [0:OTP_BYTES-1];
    logic [7:0]        otp_vld_ff, nxt_otp_vld;
    logic [4:0]        otp_grp_ff, nxt_otp_grp;
    logic [7:0]        ee_adr_ff,  nxt_ee_adr;
    logic [7:0]        ee_dat_ff,  nxt_ee_dat;
    logic              ack_ff,     nxt_ack;
    logic [7:0]        rdat_ff,    nxt_rdat;
    logic              started_ff;
    nvpc_strap_t       strap_ff,   nxt_strap;
    logic              unprot_ff,  nxt_unprot;
    logic [11:0]       hold_cnt_ff, nxt_hold_cnt;
    logic              hold_n_ff,  nxt_hold_n;
    logic [7:0]        portb_pulldown_enable_ff, portc_pulldown_enable_ff;
    logic              wwait_ff;

    // ==========================================================
    // Bus decode
    logic [13:0] idx;
    logic        req, wr_now, hit_ctl, hit_ee, hit_otp;
    logic [7:0]  wbyte, fix_opt, ee_opt;
    logic        otp_commit, ee_commit, ee_allowed, prot_active;

    assign idx     = ADR_I[15:2];
    assign req     = CYC_I && STB_I;
    // Writes take effect on the edge where ack is seen high
    assign wr_now  = req && ack_ff && WE_I && SEL_I[0];
    assign hit_ctl = (idx == IDX_CTRL);
    assign hit_ee  = (idx[13:8] == EE_PAGE);
    assign hit_otp = (idx[13:8] == OTP_PAGE);
    assign wbyte   = DAT_I[7:0];
    assign fix_opt = otp_mem[FIX_OPT_OFS];
    assign ee_opt  = ee_mem[EE_OPT_OFS];

    // Protection off in bootstrap or once the option was erased
    assign prot_active = !unprot_ff && !strap_ff.boot;
    assign ee_allowed  = (ee_adr_ff < EE_PART2_BASE) || !prot_active;

    // Dropping a latch with its program enable set commits the op; EEPROM also needs an unprotected address
    assign otp_commit = ctl_ff.otp_latch_enable && !nxt_ctl.otp_latch_enable
                        && ctl_ff.otp_program_enable;
    assign ee_commit  = ctl_ff.eeprom_latch_enable
                        && !nxt_ctl.eeprom_latch_enable
                        && ctl_ff.eeprom_pump_enable && ee_allowed;

    // ==========================================================
    // Control register and capture latches, next values
    always_comb begin
        nvpc_ctl_t w;
        w           = nvpc_ctl_t'(wbyte);
        nxt_ctl     = ctl_ff;
        nxt_otp_vld = otp_vld_ff;
        nxt_otp_grp = otp_grp_ff;
        nxt_ee_adr  = ee_adr_ff;
        nxt_ee_dat  = ee_dat_ff;
        nxt_ee_st   = ee_st_ff;
        for (int k = 0; k < OTP_BYTES; k++) begin
            nxt_otp_dat[k] = otp_dat_ff[k];
        end
        if (wr_now && hit_ctl) begin
            nxt_ctl.clock_output_select = w.clock_output_select;
            nxt_ctl.otp_latch_enable    = w.otp_latch_enable;
            // Only a one is taken, and only with data latched
            if (w.otp_program_enable && ctl_ff.otp_latch_enable
                && (otp_vld_ff != 8'h00)) begin
                nxt_ctl.otp_program_enable = 1'b1;
            end
            nxt_ctl.eeprom_latch_enable = w.eeprom_latch_enable;
            if (ee_st_ff != EE_LOADED && ee_st_ff != EE_PUMP) begin
                nxt_ctl.eeprom_erase_select = w.eeprom_erase_select;
            end
            if (w.eeprom_pump_enable && ee_st_ff == EE_LOADED) begin
                nxt_ctl.eeprom_pump_enable = 1'b1;
            end
        end
        // Latched OTP write lands in the latch, not the array
        if (wr_now && hit_otp && ctl_ff.otp_latch_enable
            && !ctl_ff.otp_program_enable) begin
            if (otp_grp_ff != idx[7:3]) begin
                nxt_otp_vld = 8'h00;   // New group drops old bytes
            end
            nxt_otp_grp = idx[7:3];
            nxt_otp_dat[idx[2:0]] = wbyte;
            nxt_otp_vld[idx[2:0]] = 1'b1;
        end
        // Latched EEPROM write captures address and data
        if (wr_now && hit_ee && ctl_ff.eeprom_latch_enable
            && !ctl_ff.eeprom_pump_enable) begin
            nxt_ee_adr = idx[7:0];
            nxt_ee_dat = wbyte;
        end
        // Stop mode drops both latches at once
        if (STOP_MODE) begin
            nxt_ctl.otp_latch_enable    = 1'b0;
            nxt_ctl.eeprom_latch_enable = 1'b0;
        end
        if (!nxt_ctl.otp_latch_enable) begin
            nxt_ctl.otp_program_enable = 1'b0;
            nxt_otp_vld                = 8'h00;
        end
        if (!nxt_ctl.eeprom_latch_enable) begin
            nxt_ctl.eeprom_erase_select = 1'b0;
            nxt_ctl.eeprom_pump_enable  = 1'b0;
        end
        nxt_ctl.unused = 2'b00;
        // EEPROM sequence tracker
        case (ee_st_ff)
            EE_IDLE: begin
                if (nxt_ctl.eeprom_latch_enable) begin
                    nxt_ee_st = EE_READY;
                end
            end
            EE_READY: begin
                if (!nxt_ctl.eeprom_latch_enable) begin
                    nxt_ee_st = EE_IDLE;
                end else if (nxt_ee_adr != ee_adr_ff
                             || (wr_now && hit_ee)) begin
                    nxt_ee_st = EE_LOADED;
                end
            end
            EE_LOADED: begin
                if (!nxt_ctl.eeprom_latch_enable) begin
                    nxt_ee_st = EE_IDLE;
                end else if (nxt_ctl.eeprom_pump_enable) begin
                    nxt_ee_st = EE_PUMP;
                end
            end
            EE_PUMP: begin
                if (!nxt_ctl.eeprom_latch_enable) begin
                    nxt_ee_st = EE_IDLE;
                end
            end
            default: nxt_ee_st = EE_IDLE;
        endcase
    end

    // Control registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctl_ff     <= nvpc_ctl_t'(CTL_RESET);
            ee_st_ff   <= EE_IDLE;
            otp_vld_ff <= 8'h00;
            otp_grp_ff <= 5'h00;
            ee_adr_ff  <= 8'h00;
            ee_dat_ff  <= 8'h00;
            for (int k = 0; k < OTP_BYTES; k++) begin
                otp_dat_ff[k] <= 8'h00;
            end
        end else begin
            ctl_ff     <= nxt_ctl;
            ee_st_ff   <= nxt_ee_st;
            otp_vld_ff <= nxt_otp_vld;
            otp_grp_ff <= nxt_otp_grp;
            ee_adr_ff  <= nxt_ee_adr;
            ee_dat_ff  <= nxt_ee_dat;
            for (int k = 0; k < OTP_BYTES; k++) begin
                otp_dat_ff[k] <= nxt_otp_dat[k];
            end
        end
    end

    // ==========================================================
    // Arrays: nonvolatile, so no reset
    always_ff @(posedge CLK) begin
        if (UV_ERASE) begin
            for (int a = 0; a < 256; a++) begin
                otp_mem[a] <= OTP_ERASED;
            end
        end else if (otp_commit) begin
            for (int k = 0; k < OTP_BYTES; k++) begin
                if (otp_vld_ff[k]) begin
                    // Programming only adds ones
                    otp_mem[{otp_grp_ff, 3'(k)}] <=
                        otp_mem[{otp_grp_ff, 3'(k)}] | otp_dat_ff[k];
                end
            end
        end
        if (ee_commit) begin
            if (ctl_ff.eeprom_erase_select) begin
                ee_mem[ee_adr_ff] <= EE_ERASED;
            end else begin
                ee_mem[ee_adr_ff] <= ee_mem[ee_adr_ff] & ee_dat_ff;
            end
        end
    end

    // ==========================================================
    // Wishbone answer, next values
    always_comb begin
        nxt_ack  = req && !ack_ff;
        nxt_rdat = 8'h00;
        if (hit_ctl) begin
            nxt_rdat = ctl_ff;
        end else if (hit_otp) begin
            // Latched array gives no true contents
            nxt_rdat = ctl_ff.otp_latch_enable ? OTP_LATCH_READ
                                               : otp_mem[idx[7:0]];
        end else if (hit_ee) begin
            nxt_rdat = ee_mem[idx[7:0]];
        end
    end

    // Wishbone registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_ff  <= 1'b0;
            rdat_ff <= 8'h00;
        end else begin
            ack_ff  <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end

    // ==========================================================
    // Reset-time options, caught once after release
    always_comb begin
        nxt_strap    = strap_ff;
        nxt_unprot   = unprot_ff;
        nxt_hold_cnt = hold_cnt_ff;
        nxt_hold_n   = hold_n_ff;
        if (!started_ff) begin
            nxt_strap.secure     = !ee_opt[OPT_SECURITY];
            nxt_strap.wdog_reset = fix_opt[FIX_WDOG_RST]
                                   && !BOOT_MODE;
            nxt_strap.boot       = BOOT_MODE;
            nxt_strap.por        = POR_FLAG;
            nxt_strap.hold_sel   = fix_opt[FIX_HOLD_SEL];
            nxt_unprot           = ee_opt[OPT_UPPER_PROT];
            // Short hold when the option is set
            nxt_hold_cnt = fix_opt[FIX_HOLD_SEL] ? HOLD_SHORT
                                                 : HOLD_LONG;
            nxt_hold_n   = !POR_FLAG;
        end else begin
            // Once erased the part stays open until next reset
            if (ee_opt[OPT_UPPER_PROT]) begin
                nxt_unprot = 1'b1;
            end
            if (hold_cnt_ff != 12'd0) begin
                nxt_hold_cnt = hold_cnt_ff - 12'd1;
            end
            if (hold_cnt_ff == 12'd1) begin
                nxt_hold_n = 1'b1;
            end
        end
    end

    // Option registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            started_ff  <= 1'b0;
            strap_ff    <= '0;
            unprot_ff   <= 1'b0;
            hold_cnt_ff <= 12'd0;
            hold_n_ff   <= 1'b0;
        end else begin
            started_ff  <= 1'b1;
            strap_ff    <= nxt_strap;
            unprot_ff   <= nxt_unprot;
            hold_cnt_ff <= nxt_hold_cnt;
            hold_n_ff   <= nxt_hold_n;
        end
    end

    // ==========================================================
    // Pin-side option effects, registered
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            portb_pulldown_enable_ff  <= 8'h00;
            portc_pulldown_enable_ff  <= 8'h00;
            wwait_ff <= 1'b0;
        end else begin
            portb_pulldown_enable_ff  <= fix_opt[FIX_PB_PD] ? ~DDRB : 8'h00;
            portc_pulldown_enable_ff  <= fix_opt[FIX_PC_PD] ? ~DDRC : 8'h00;
            wwait_ff <= !WAIT_MODE || fix_opt[FIX_WDOG_WAIT];
        end
    end

    // ==========================================================
    // Outputs, all from flip-flops
    assign DAT_O           = {24'h000000, rdat_ff};
    assign ACK_O           = ack_ff;
    assign RESET_HOLD_N    = hold_n_ff;
    assign WDOG_DEFAULT_ON = strap_ff.wdog_reset;
    assign WDOG_WAIT_RUN   = wwait_ff;
    assign PB_PULLDOWN     = portb_pulldown_enable_ff;
    assign PC_PULLDOWN     = portc_pulldown_enable_ff;
    assign SECURE_LOCK     = strap_ff.secure;
    assign VECTOR_BLOCK    = ctl_ff.otp_latch_enable;
    assign PUMP_ON         = ctl_ff.eeprom_pump_enable;
    assign OTP_PGM_ON      = ctl_ff.otp_program_enable;

    // ==========================================================
    // Checks
    AST_EE_FORCE: assert property (@(posedge CLK) disable iff (!RST_N)
        !ctl_ff.eeprom_latch_enable |-> !ctl_ff.eeprom_erase_select
        && !ctl_ff.eeprom_pump_enable) else $error("EE bits not forced");
    AST_PGM_NEEDS_DATA: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(ctl_ff.otp_program_enable) |-> ctl_ff.otp_latch_enable
        && $past(otp_vld_ff) != 8'h00) else $error("PGM set early");
    AST_STOP_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
        STOP_MODE |=> !ctl_ff.otp_latch_enable
        && !ctl_ff.eeprom_latch_enable) else $error("Stop kept latch");
    AST_LATCH_READ: assert property (@(posedge CLK) disable iff (!RST_N)
        (req && !ack_ff && !WE_I && hit_otp && ctl_ff.otp_latch_enable)
        |=> ACK_O && DAT_O[7:0] == OTP_LATCH_READ)
        else $error("True OTP data while latched");
    AST_PUMP_LOADED: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(ctl_ff.eeprom_pump_enable) |-> $past(ee_st_ff) == EE_LOADED)
        else $error("Pump set without data");
    AST_ERA_FROZEN: assert property (@(posedge CLK) disable iff (!RST_N)
        ($past(ee_st_ff) == EE_LOADED && ctl_ff.eeprom_latch_enable)
        |-> $stable(ctl_ff.eeprom_erase_select))
        else $error("Erase select changed");
    AST_HOLD_END: assert property (@(posedge CLK) disable iff (!RST_N)
        (started_ff && hold_cnt_ff == 12'd1) |=> RESET_HOLD_N)
        else $error("Reset hold not released");
    AST_SEC_STABLE: assert property (@(posedge CLK) disable iff (!RST_N)
        started_ff |=> SECURE_LOCK === $past(SECURE_LOCK))
        else $error("Security changed without reset");
    AST_PULLDOWN_OFF: assert property (@(posedge CLK) disable iff (!RST_N)
        (DDRB == 8'hFF) |=> PB_PULLDOWN == 8'h00)
        else $error("Pull-down on output pin");
endmodule // nvpc_ctrl

// ### logic/nvpc_pkg.sv
// Purpose: Constants and types for the OTP/EEPROM program control block
// Assumes: Register index = byte address / 4 on a 32-bit Wishbone bus
// Notes:   Only the low byte of each word carries data
package nvpc_pkg;
    // ==========================================================
    // Register indices and windows
    localparam logic [13:0] IDX_CTRL      = 14'h0007;
    localparam logic [13:0] IDX_EE_OPT    = 14'h0100;
    localparam logic [13:0] IDX_FIX_OPT   = 14'h3DFE;
    localparam logic [5:0]  EE_PAGE       = 6'h01;
    localparam logic [5:0]  OTP_PAGE      = 6'h3D;
    localparam logic [7:0]  EE_OPT_OFS    = 8'h00;
    localparam logic [7:0]  FIX_OPT_OFS   = 8'hFE;
    localparam logic [7:0]  EE_PART2_BASE = 8'h20;
    // ==========================================================
    // Field positions
    localparam int OPT_UPPER_PROT = 1;
    localparam int OPT_SECURITY   = 0;
    localparam int FIX_HOLD_SEL   = 4;
    localparam int FIX_WDOG_RST   = 3;
    localparam int FIX_WDOG_WAIT  = 2;
    localparam int FIX_PB_PD      = 1;
    localparam int FIX_PC_PD      = 0;
    // ==========================================================
    // Values
    localparam logic [7:0]  CTL_RESET      = 8'h00;
    localparam logic [7:0]  OTP_ERASED     = 8'h00;
    localparam logic [7:0]  EE_ERASED      = 8'hFF;
    localparam logic [7:0]  OTP_LATCH_READ = 8'hFF;
    localparam logic [11:0] HOLD_SHORT     = 12'd16;
    localparam logic [11:0] HOLD_LONG      = 12'd4064;
    localparam int          OTP_BYTES      = 8;
    // ==========================================================
    // Types
    typedef struct packed {
        logic [1:0] unused;
        logic       otp_latch_enable;
        logic       otp_program_enable;
        logic       clock_output_select;
        logic       eeprom_erase_select;
        logic       eeprom_latch_enable;
        logic       eeprom_pump_enable;
    } nvpc_ctl_t;

    typedef struct packed {
        logic       secure;
        logic       wdog_reset;
        logic       boot;
        logic       por;
        logic       hold_sel;
    } nvpc_strap_t;

    typedef enum logic [1:0] {
        EE_IDLE   = 2'b00,
        EE_READY  = 2'b01,
        EE_LOADED = 2'b11,
        EE_PUMP   = 2'b10
    } nvpc_ee_st_t;
endpackage
